//--- shared/bus_hold_consts.svh
/*
 * Named constants for the bus hold and snoop response block.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef BUS_HOLD_CONSTS_SVH
`define BUS_HOLD_CONSTS_SVH

`define SNOOP_START_DELAY 2'h2
`define LINE_TAG_W 27
`define CACHE_LINES 8
`define CACHE_IDX_W 3
`define MAX_OUTSTANDING 2'h2
`define BURST_BEATS 2'h3

`endif

//--- shared/bus_hold_pkg.sv
/*
 * Types shared by the bus hold and snoop response design.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package bus_hold_pkg;

    // Gray-coded hold handshake states
    typedef enum logic [1:0] {
        HOLD_IDLE = 2'b00,
        HOLD_DRAIN = 2'b01,
        HOLD_GRANTED = 2'b11
    } hold_state_t;

    typedef enum logic [1:0] {
        LINE_INVALID = 2'b00,
        LINE_SHARED = 2'b01,
        LINE_EXCLUSIVE = 2'b11,
        LINE_MODIFIED = 2'b10
    } line_state_t;

endpackage
`default_nettype wire

//--- src/snoop_tag_mem.sv
/*
 * Small tag and state memory standing in for the cache directory.
 * Assumes one writer (the core side) and one registered read port.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bus_hold_consts.svh"

module snoop_tag_mem (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [`CACHE_IDX_W-1:0] wr_idx,
    input wire logic [`LINE_TAG_W-1:0] wr_tag,
    input wire logic [1:0] wr_state,
    input wire logic [`CACHE_IDX_W-1:0] rd_idx,
    output logic [`LINE_TAG_W-1:0] rd_tag_ff,
    output logic [1:0] rd_state_ff
);

    logic [`LINE_TAG_W-1:0] tag_mem [`CACHE_LINES];
    logic [1:0] state_mem [`CACHE_LINES];

    // =====================================================
    // Storage
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            tag_mem[wr_idx] <= wr_tag;
        end
    end

    // State is cleared at reset so no stale line can hit
    genvar gi;
    generate
        for (gi = 0; gi < `CACHE_LINES; gi = gi + 1) begin : g_state
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    state_mem[gi] <= 2'h0;
                end else if (wr_en &&
                        wr_idx == `CACHE_IDX_W'(gi)) begin
                    state_mem[gi] <= wr_state;
                end
            end
        end
    endgenerate

    // =====================================================
    // Registered read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_tag_ff <= '0;
            rd_state_ff <= 2'h0;
        end else begin
            rd_tag_ff <= tag_mem[rd_idx];
            rd_state_ff <= state_mem[rd_idx];
        end
    end

endmodule
`default_nettype wire

//--- src/bus_hold_snoop.sv
/*
 * Bus hold handshake and inquire-cycle response of the processor bus.
 * Assumes all inputs synchronous to sys_clk; the core bus logic reports
 * its own strobes on cycle_addr_strobe and its locks on core_locked.
 * Active-low pins are presented here as active-high levels.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bus_hold_consts.svh"

// Function
// - Snoop hit when inquired line is valid: modified, exclusive or shared.
// - Hit changes only the edge after snoop strobe; holds till next inquire.
// - Dirty asserted for modified line; a writeback of it is requested.
// - Snoop on line already being written back: dirty, no second writeback.
// - Dirty result presented edge after snoop strobe; negated value holds.
// - Dirty stays through writeback, drops edge after its last burst ready; code drops it on the first final burst ready of any cycle.
// - On request, finish cycles and float on the same edge as ack; never inside a lock.
// - While acked, float address, strobes, data, status, lock and the rest.
// - Cycle in progress: ack one edge after its final burst ready.
// - Bus idle: ack one edge after request sampled.
// - Ack negated one edge after request sampled negated.
// - Ack assertion ignores the backoff input.
// - Bus floated on every clock with ack asserted.
// - Ack always driven except test float, glitch free from a flop.
// - Request sampled every edge, honoured during warm restart or reset.
// - Snoop strobe sampled from two edges after ack asserted.
module bus_hold_snoop (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic test_float,
    input wire logic bus_hold_req,
    input wire logic backoff_in,
    input wire logic cycle_addr_strobe,
    input wire logic burst_ready_in,
    input wire logic last_beat,
    input wire logic core_locked,
    input wire logic snoop_addr_strobe,
    input wire logic [31:3] snoop_addr,
    input wire logic tag_wr_en,
    input wire logic [`CACHE_IDX_W-1:0] tag_wr_idx,
    input wire logic [`LINE_TAG_W-1:0] tag_wr_tag,
    input wire logic [1:0] tag_wr_state,
    output logic bus_grant_ack_ff,
    output logic bus_grant_ack_oe_ff,
    output logic bus_float_ff,
    output logic snoop_match_ff,
    output logic snoop_match_oe_ff,
    output logic snoop_dirty_out_ff,
    output logic snoop_dirty_oe_ff,
    output logic wb_req_ff
);

    bus_hold_pkg::hold_state_t state_ff;
    bus_hold_pkg::hold_state_t nxt_state;
    logic [1:0] outstanding_ff;
    logic [1:0] snoop_wait_ff;
    logic snoop_pend_ff;
    logic [`LINE_TAG_W-1:0] snoop_tag_ff;
    logic [`LINE_TAG_W-1:0] rd_tag;
    logic [1:0] rd_state;
    logic wb_active_ff;
    logic [`LINE_TAG_W-1:0] wb_tag_ff;
    logic final_ready;
    logic bus_idle;
    logic snoop_ok;
    logic hit;
    logic dirty;

    function automatic logic [`CACHE_IDX_W-1:0] line_idx(
        input logic [31:3] a
    );
        line_idx = a[`CACHE_IDX_W+4:5];
    endfunction

    function automatic logic [`LINE_TAG_W-1:0] line_tag(
        input logic [31:3] a
    );
        line_tag = a[31:32-`LINE_TAG_W];
    endfunction

    // =====================================================
    // Outstanding cycle tracking
    assign final_ready = burst_ready_in && last_beat;
    assign bus_idle = (outstanding_ff == 2'h0);

    always_ff @(posedge sys_clk) begin
        if (rst || backoff_in) begin
            outstanding_ff <= 2'h0;
        end else begin
            case ({cycle_addr_strobe && !bus_float_ff,
                    final_ready && outstanding_ff != 2'h0})
                2'b10: outstanding_ff <= outstanding_ff + 2'h1;
                2'b01: outstanding_ff <= outstanding_ff - 2'h1;
                default: outstanding_ff <= outstanding_ff;
            endcase
        end
    end

    // =====================================================
    // Hold handshake; the request is honoured even in reset
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bus_hold_pkg::HOLD_IDLE: begin
                if (bus_hold_req) begin
                    nxt_state = bus_hold_pkg::HOLD_DRAIN;
                end
            end
            bus_hold_pkg::HOLD_DRAIN: begin
                if (!bus_hold_req) begin
                    nxt_state = bus_hold_pkg::HOLD_IDLE;
                end else if (!core_locked && (bus_idle ||
                        (outstanding_ff == 2'h1 && final_ready))) begin
                    nxt_state = bus_hold_pkg::HOLD_GRANTED;
                end
            end
            bus_hold_pkg::HOLD_GRANTED: begin
                if (!bus_hold_req) begin
                    nxt_state = bus_hold_pkg::HOLD_IDLE;
                end
            end
            default: nxt_state = bus_hold_pkg::HOLD_IDLE;
        endcase
    end

    // Idle bus with request: grant at once, one edge after sampling
    always_ff @(posedge sys_clk) begin
        if (bus_hold_req && !core_locked &&
                (state_ff != bus_hold_pkg::HOLD_GRANTED) &&
                (bus_idle && !cycle_addr_strobe ||
                 outstanding_ff == 2'h1 && final_ready)) begin
            state_ff <= bus_hold_pkg::HOLD_GRANTED;
        end else if (rst && !bus_hold_req) begin
            state_ff <= bus_hold_pkg::HOLD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Ack and float from the same flop decision: no glitch, no gap
    always_ff @(posedge sys_clk) begin
        bus_grant_ack_ff <= (nxt_state == bus_hold_pkg::HOLD_GRANTED) ||
            (bus_hold_req && !core_locked &&
             state_ff != bus_hold_pkg::HOLD_GRANTED &&
             (bus_idle && !cycle_addr_strobe ||
              outstanding_ff == 2'h1 && final_ready));
        bus_grant_ack_oe_ff <= !test_float;
    end

    // Float also covers backoff so a pending cycle cannot drive
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_float_ff <= 1'b1;
        end else begin
            bus_float_ff <= backoff_in || (bus_hold_req && !core_locked &&
                state_ff != bus_hold_pkg::HOLD_GRANTED &&
                (bus_idle && !cycle_addr_strobe ||
                 outstanding_ff == 2'h1 && final_ready)) ||
                (nxt_state == bus_hold_pkg::HOLD_GRANTED);
        end
    end

    // =====================================================
    // Snoop strobe qualification
    always_ff @(posedge sys_clk) begin
        if (rst || !bus_grant_ack_ff) begin
            snoop_wait_ff <= 2'h0;
        end else if (snoop_wait_ff != `SNOOP_START_DELAY - 2'h1) begin
            snoop_wait_ff <= snoop_wait_ff + 2'h1;
        end
    end

    // Strobe ignored the edge after one is taken, and while dirty
    // Count only starts the edge after ack rose, hence one less
    assign snoop_ok = snoop_addr_strobe && !snoop_pend_ff &&
        !snoop_dirty_out_ff &&
        (!bus_grant_ack_ff ||
         snoop_wait_ff == `SNOOP_START_DELAY - 2'h1);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snoop_pend_ff <= 1'b0;
            snoop_tag_ff <= '0;
        end else begin
            snoop_pend_ff <= snoop_ok;
            if (snoop_ok) begin
                snoop_tag_ff <= line_tag(snoop_addr);
            end
        end
    end

    snoop_tag_mem u_tag_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(tag_wr_en),
        .wr_idx(tag_wr_idx),
        .wr_tag(tag_wr_tag),
        .wr_state(tag_wr_state),
        .rd_idx(line_idx(snoop_addr)),
        .rd_tag_ff(rd_tag),
        .rd_state_ff(rd_state)
    );

    // =====================================================
    // Hit and dirty results
    // Directory lookup is registered, so the result lands on the edge
    // after the strobe is taken
    assign hit = (rd_tag == snoop_tag_ff) &&
        (rd_state != bus_hold_pkg::LINE_INVALID);
    assign dirty = (rd_tag == snoop_tag_ff) &&
        (rd_state == bus_hold_pkg::LINE_MODIFIED);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snoop_match_ff <= 1'b0;
        end else if (snoop_pend_ff) begin
            snoop_match_ff <= hit;
        end
        snoop_match_oe_ff <= !test_float;
        snoop_dirty_oe_ff <= !test_float;
    end

    // Writeback ownership: the line in flight is never queued twice
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            snoop_dirty_out_ff <= 1'b0;
            wb_req_ff <= 1'b0;
            wb_active_ff <= 1'b0;
            wb_tag_ff <= '0;
        end else if (snoop_pend_ff) begin
            snoop_dirty_out_ff <= dirty || (wb_active_ff &&
                wb_tag_ff == snoop_tag_ff);
            wb_req_ff <= dirty && !(wb_active_ff &&
                wb_tag_ff == snoop_tag_ff);
            if (dirty) begin
                wb_active_ff <= 1'b1;
                wb_tag_ff <= snoop_tag_ff;
            end
        end else begin
            wb_req_ff <= 1'b0;
            if (wb_active_ff && final_ready && !bus_float_ff) begin
                snoop_dirty_out_ff <= 1'b0;
                wb_active_ff <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

//--- sim/bus_hold_snoop_assertions.sv
/*
 * Port checker for bus_hold_snoop, bound into every instance.
 * Assumes all ports synchronous to sys_clk and rst synchronous.
 */
`timescale 1ns/100ps
`default_nettype none

module bus_hold_snoop_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic test_float,
    input wire logic bus_hold_req,
    input wire logic backoff_in,
    input wire logic cycle_addr_strobe,
    input wire logic burst_ready_in,
    input wire logic last_beat,
    input wire logic core_locked,
    input wire logic snoop_addr_strobe,
    input wire logic bus_grant_ack_ff,
    input wire logic bus_grant_ack_oe_ff,
    input wire logic bus_float_ff,
    input wire logic snoop_match_ff,
    input wire logic snoop_match_oe_ff,
    input wire logic snoop_dirty_out_ff,
    input wire logic snoop_dirty_oe_ff,
    input wire logic wb_req_ff
);
    // ========================================
    // Outstanding cycles and writeback tracking
    logic [1:0] out_cnt_ff;
    logic wb_cyc_ff;
    wire logic fin = burst_ready_in && last_beat;
    wire logic out_ok = !core_locked &&
        (out_cnt_ff == 2'h0 || (out_cnt_ff == 2'h1 && fin));
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Backoff aborts whatever was outstanding
    always_ff @(posedge sys_clk) begin
        if (rst || backoff_in) begin
            out_cnt_ff <= 2'h0;
        end else begin
            out_cnt_ff <= out_cnt_ff + {1'b0, cycle_addr_strobe} - {1'b0, fin};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (rst || fin) begin
            wb_cyc_ff <= 1'b0;
        end else if (cycle_addr_strobe && snoop_dirty_out_ff) begin
            wb_cyc_ff <= 1'b1;
        end
    end

    ack_on_time_a: assert property (
        bus_hold_req && out_ok && !cycle_addr_strobe |=> bus_grant_ack_ff)
        else $error("hold ack late");
    ack_not_early_a: assert property (
        $rose(bus_grant_ack_ff) |-> $past(out_ok))
        else $error("hold ack before bus free");
    ack_drop_a: assert property (
        bus_grant_ack_ff && !bus_hold_req |=> !bus_grant_ack_ff)
        else $error("hold ack not dropped");
    ack_float_a: assert property (
        bus_grant_ack_ff |-> bus_float_ff) else $error("bus driven in hold");
    pin_oe_a: assert property (
        1'b1 |=> {bus_grant_ack_oe_ff, snoop_match_oe_ff, snoop_dirty_oe_ff}
        == {3{!$past(test_float)}}) else $error("output enable wrong");
    match_hold_a: assert property (
        !$past(snoop_addr_strobe, 2) |-> $stable(snoop_match_ff))
        else $error("match changed without inquire");
    dirty_rise_a: assert property (
        $rose(snoop_dirty_out_ff) |-> $past(snoop_addr_strobe, 2) && wb_req_ff)
        else $error("dirty rose without inquire");
    dirty_keep_a: assert property (
        snoop_dirty_out_ff && !fin |=> snoop_dirty_out_ff)
        else $error("dirty dropped early");
    dirty_drop_a: assert property (
        snoop_dirty_out_ff && fin && wb_cyc_ff |=> !snoop_dirty_out_ff)
        else $error("dirty not dropped");
    wb_pulse_a: assert property (
        wb_req_ff |=> !wb_req_ff) else $error("writeback request held");
endmodule

bind bus_hold_snoop bus_hold_snoop_chk i_chk (.sys_clk, .rst, .test_float,
    .bus_hold_req, .backoff_in, .cycle_addr_strobe, .burst_ready_in,
    .last_beat, .core_locked, .snoop_addr_strobe, .bus_grant_ack_ff,
    .bus_grant_ack_oe_ff, .bus_float_ff, .snoop_match_ff, .snoop_match_oe_ff,
    .snoop_dirty_out_ff, .snoop_dirty_oe_ff, .wb_req_ff);

`default_nettype wire

//--- sim/bus_resp_model.sv
/*
 * System-side responder: four burst ready beats per strobed cycle.
 * Assumes strobes come at least wait_n plus five cycles apart.
 */
`timescale 1ns/100ps
`default_nettype none

module bus_resp_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cycle_addr_strobe,
    input wire logic [3:0] wait_n,
    output logic burst_ready_in,
    output logic last_beat
);
    // ========================================
    // Beat sequencer
    int cnt;

    // Answers strobes only, never snoop results
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt <= 0;
            burst_ready_in <= 1'b0;
            last_beat <= 1'b0;
        end else begin
            if (cycle_addr_strobe) begin
                cnt <= int'(wait_n) + 4;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
            burst_ready_in <= cnt >= 1 && cnt <= 4;
            // Qualifier is junk between beats, not a stale value
            last_beat <= (cnt >= 1 && cnt <= 4) ? cnt == 1 : !last_beat;
        end
    end
endmodule

`default_nettype wire

//--- sim/tb_bus_hold_and_inquire_response.sv
/*
 * Testbench for bus_hold_snoop with the system-side responder.
 * Assumes the checker is bound in by its own file.
 */
`timescale 1ns/100ps
`default_nettype none
`include "bus_hold_consts.svh"

module tb_bus_hold_and_inquire_response;
    // ========================================
    // Signals and instances
    logic sys_clk, rst, test_float, bus_hold_req, backoff_in, core_locked;
    logic cycle_addr_strobe, burst_ready_in, last_beat, snoop_addr_strobe;
    logic [31:3] snoop_addr;
    logic tag_wr_en;
    logic [`CACHE_IDX_W-1:0] tag_wr_idx;
    logic [`LINE_TAG_W-1:0] tag_wr_tag;
    logic [1:0] tag_wr_state;
    logic bus_grant_ack_ff, bus_grant_ack_oe_ff, bus_float_ff, wb_req_ff;
    logic snoop_match_ff, snoop_match_oe_ff, snoop_dirty_out_ff;
    logic snoop_dirty_oe_ff;
    logic [3:0] wait_n;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    bus_hold_snoop i_dut (.sys_clk, .rst, .test_float, .bus_hold_req,
        .backoff_in, .cycle_addr_strobe, .burst_ready_in, .last_beat,
        .core_locked, .snoop_addr_strobe, .snoop_addr, .tag_wr_en,
        .tag_wr_idx, .tag_wr_tag, .tag_wr_state, .bus_grant_ack_ff,
        .bus_grant_ack_oe_ff, .bus_float_ff, .snoop_match_ff,
        .snoop_match_oe_ff, .snoop_dirty_out_ff, .snoop_dirty_oe_ff,
        .wb_req_ff);
    bus_resp_model i_resp (.sys_clk, .rst, .cycle_addr_strobe, .wait_n,
        .burst_ready_in, .last_beat);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ========================================
    // Shared tasks
    task chk(input string nm, input logic s, input logic e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, e, s);
        end
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // Runs a strobed cycle; sel picks ack or dirty to follow its last beat
    task run_cycle(input logic sel);
        logic fin;
        cycle_addr_strobe = 1'b1;
        step(1);
        cycle_addr_strobe = 1'b0;
        bus_hold_req = sel;
        for (int i = 0; i < 20; i++) begin
            fin = burst_ready_in && last_beat;
            step(1);
            chk("follow", sel ? bus_grant_ack_ff : snoop_dirty_out_ff,
                sel ? fin : !fin);
            if (fin) break;
        end
    endtask

    // ========================================
    // Scenarios
    task t_idle_hold;
        backoff_in = 1'b1;
        bus_hold_req = 1'b1;
        step(1);
        chk("idle ack", bus_grant_ack_ff, 1'b1);
        backoff_in = 1'b0;
        step(2);
        chk("ack kept", bus_grant_ack_ff, 1'b1);
        chk("float", bus_float_ff, 1'b1);
        bus_hold_req = 1'b0;
        step(1);
        chk("ack off", bus_grant_ack_ff, 1'b0);
    endtask
    task t_busy_hold;
        wait_n = 4'h3;
        run_cycle(1'b1);
        chk("busy ack", bus_grant_ack_ff, 1'b1);
        bus_hold_req = 1'b0;
        core_locked = 1'b1;
        step(1);
        bus_hold_req = 1'b1;
        step(3);
        chk("locked ack", bus_grant_ack_ff, 1'b0);
        core_locked = 1'b0;
        step(1);
        chk("unlock ack", bus_grant_ack_ff, 1'b1);
        bus_hold_req = 1'b0;
        step(2);
    endtask
    task t_snoop;
        bus_hold_pkg::line_state_t st[4];
        logic prev, hit, mod;
        st = '{bus_hold_pkg::LINE_SHARED, bus_hold_pkg::LINE_INVALID,
            bus_hold_pkg::LINE_EXCLUSIVE, bus_hold_pkg::LINE_MODIFIED};
        tag_wr_en = 1'b1;
        for (int k = 0; k < 4; k++) begin
            tag_wr_idx = 3'(k);
            tag_wr_tag = 27'h000_0050 + 27'(k);
            tag_wr_state = st[k];
            step(1);
        end
        tag_wr_en = 1'b0;
        // Last pass: valid index 0 with a foreign tag must miss
        for (int k = 0; k < 5; k++) begin
            prev = snoop_match_ff;
            hit = k < 4 && st[k % 4] != bus_hold_pkg::LINE_INVALID;
            mod = k < 4 && st[k % 4] == bus_hold_pkg::LINE_MODIFIED;
            snoop_addr = {(k < 4) ? 27'h000_0050 + 27'(k) : 27'h000_0100, 2'h0};
            snoop_addr_strobe = 1'b1;
            step(1);
            snoop_addr_strobe = 1'b0;
            chk("match early", snoop_match_ff, prev);
            step(1);
            chk("match", snoop_match_ff, hit);
            chk("dirty", snoop_dirty_out_ff, mod);
            chk("wb req", wb_req_ff, mod);
            step(2);
            chk("dirty hold", snoop_dirty_out_ff, mod);
            if (mod) run_cycle(1'b0);
        end
    endtask
    // Snoop under hold: refused one edge after ack, taken at two
    task t_hold_snoop;
        bus_hold_req = 1'b1;
        snoop_addr = {27'h000_0052, 2'h0};
        step(1);
        chk("hold ack", bus_grant_ack_ff, 1'b1);
        snoop_addr_strobe = 1'b1;
        step(2);
        snoop_addr_strobe = 1'b0;
        chk("snoop too soon", snoop_match_ff, 1'b0);
        step(1);
        chk("snoop in hold", snoop_match_ff, 1'b1);
        bus_hold_req = 1'b0;
        step(2);
    endtask
    task t_float;
        test_float = 1'b1;
        step(1);
        chk("ack oe", bus_grant_ack_oe_ff, 1'b0);
        chk("match oe", snoop_match_oe_ff, 1'b0);
        test_float = 1'b0;
        step(1);
        chk("dirty oe", snoop_dirty_oe_ff, 1'b1);
        chk("ack oe on", bus_grant_ack_oe_ff, 1'b1);
        chk("match oe on", snoop_match_oe_ff, 1'b1);
    endtask

    // ========================================
    // Main sequence and hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        {test_float, backoff_in, core_locked, cycle_addr_strobe} = 4'h0;
        {snoop_addr_strobe, tag_wr_en, tag_wr_idx, tag_wr_state} = 7'h00;
        snoop_addr = 29'h0000_0000;
        tag_wr_tag = 27'h000_0000;
        wait_n = 4'h0;
        rst = 1'b1;
        bus_hold_req = 1'b1;
        step(3);
        chk("reset ack", bus_grant_ack_ff, 1'b1);
        rst = 1'b0;
        bus_hold_req = 1'b0;
        step(1);
        chk("reset ack off", bus_grant_ack_ff, 1'b0);
        t_idle_hold();
        t_busy_hold();
        t_snoop();
        t_hold_snoop();
        t_float();
        finish_test();
    end
endmodule

`default_nettype wire
